// >>> scgc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module scgc_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enc_go,
	input wire logic dec_go,
	input wire logic [15:0] enc_val,
	output logic enc_word_valid,
	output logic [15:0] enc_word,
	output logic dec_word_req
);
always @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		enc_word_valid <= 1'b0;
		enc_word <= 16'h0000;
		dec_word_req <= 1'b0;
	end
	else
	begin
		enc_word_valid <= enc_go;
		// idle word inverted so a late capture shows
		enc_word <= enc_go ? enc_val : ~enc_val;
		dec_word_req <= dec_go;
	end
endmodule // scgc_core_model
`default_nettype wire

// >>> scgc_map.vh
`ifndef SCGC_MAP_VH
`define SCGC_MAP_VH
// register indices; byte address is four times the index
`define SCGC_IDX_EQ_CTL 6'h2E
`define SCGC_IDX_EQ_COEF 6'h2F
`define SCGC_IDX_SC_CTL 6'h30
`define SCGC_IDX_SC_TIME 6'h31
`define SCGC_IDX_SC_FILT 6'h32
`define SCGC_IDX_ENC_DATA 6'h33
`define SCGC_IDX_SD_CTL 6'h34
`define SCGC_IDX_SD_NOISE 6'h35
`define SCGC_IDX_DEC_DATA 6'h36
`define SCGC_IDX_STATUS 6'h37
`define SCGC_IDX_GC_CTL 6'h38
`define SCGC_IDX_GC_ATT 6'h39
`define SCGC_IDX_GC_INIT 6'h3A
`define SCGC_IDX_GC_SPEED 6'h3B
`define SCGC_IDX_GC_MAX 6'h3C
`define SCGC_IDX_GC_DECAY 6'h3D
`define SCGC_IDX_IRQ_STAT 6'h3E
`define SCGC_IDX_IRQ_MASK 6'h3F
// field positions
`define SCGC_EQ_EN_BIT 15
`define SCGC_EQ_ADR_HI 13
`define SCGC_EQ_ADR_LO 8
`define SCGC_SC_EN_BIT 15
`define SCGC_SC_Q1_BIT 14
`define SCGC_SC_VC_BIT 13
`define SCGC_SC_Q0_BIT 12
`define SCGC_SC_VOX_BIT 11
`define SCGC_SC_GAP_BIT 10
`define SCGC_SD_EN_BIT 15
`define SCGC_SD_CS_BIT 14
`define SCGC_SD_SCI_BIT 8
`define SCGC_SD_CP_BIT 5
`define SCGC_SD_CN_BIT 4
`define SCGC_SD_SPD_HI 1
`define SCGC_SD_SPD_LO 0
`define SCGC_GC_EN_BIT 15
// masks of writable bits
`define SCGC_SD_CTL_MASK 16'h8133
`define SCGC_SPD_MASK 16'h0003
`define SCGC_NOISE_MASK 16'h7FFF
`define SCGC_ZERO16 16'h0000
`define SCGC_EQ_NUM 36
`define SCGC_IRQ_ENC 0
`define SCGC_IRQ_DRQ 1
`endif

// >>> scgc_regs.v
// Operation
// - equalizer control bit 15 enables the filter; register resets to zero
// - six-bit index bits 13..8 selects A1-A9, B2-B9, C1, D1-D17, C2
// - quality bits 14,12: 00 3300 avg, 10 10300 fixed, 11 5600 fixed
// - coder control holds enable, voice start, vox, gap bits, two input fields
// - coder time in 32 ms units; minimum level 16384 means 0 dB
// - low-pass equals 256 over time constant; gap time in 2 ms units
// - register transfer places each encoder word in encoder data register
// - change-speed bit reads zero; when written 1 only speed field updates
// - transfer select clear uses memory; set uses encoder/decoder data registers
// - gap compression skips gaps in replay; separate comfort noise enable
// - speed 00 normal, 01 half, 10 one and a half, 11 double
// - comfort noise level is linear scale 0 to 7FFF
// - gain control has enable bit and two input select fields
// - attenuation parameter linear, 32767 meaning 0 dB
// - low and high adaptation speeds scaled by 8192 and 256
// - decay parameter equals 256 over decay time constant
`timescale 1ns/100ps
`default_nettype none
`include "scgc_map.vh"
module scgc_regs #(
	parameter EQ_NUM = `SCGC_EQ_NUM
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire enc_word_valid,
	input wire [15:0] enc_word,
	input wire dec_word_req,
	output reg [15:0] dec_word,
	output reg dec_word_valid,
	output reg eq_enable,
	output reg [5:0] eq_coef_index,
	output reg [15:0] eq_coef_value,
	output reg [15:0] coder_ctl,
	output reg [15:0] coder_time_level,
	output reg [15:0] coder_filter_gap,
	output reg [15:0] decoder_ctl,
	output reg [15:0] decoder_noise,
	output reg [15:0] gain_ctl,
	output reg [15:0] gain_att,
	output reg [15:0] gain_init,
	output reg [15:0] gain_speed,
	output reg [15:0] gain_max,
	output reg [15:0] gain_decay,
	output reg irq
);
////////////////////////////////////////////////////////////////////////////////
reg [15:0] eq_ctl_reg;
reg [15:0] coef_mem [0:EQ_NUM-1];
reg [15:0] sc_ctl_reg;
reg [15:0] sc_time_reg;
reg [15:0] sc_filt_reg;
reg [15:0] enc_data_reg;
reg [15:0] sd_ctl_reg;
reg [15:0] sd_noise_reg;
reg [15:0] dec_data_reg;
reg [15:0] gc_ctl_reg;
reg [15:0] gc_att_reg;
reg [15:0] gc_init_reg;
reg [15:0] gc_speed_reg;
reg [15:0] gc_max_reg;
reg [15:0] gc_decay_reg;
reg drq_reg;
reg [1:0] irq_stat_reg;
reg [1:0] irq_mask_reg;
reg [1:0] irq_set;
wire access;
wire wr_en;
wire rd_en;
wire [5:0] idx;
wire mapped;
wire sci_mode;
wire [5:0] cur_index;
reg [15:0] rd_word;
reg [15:0] sd_ctl_next;
assign access = psel & penable & pready;
// refused accesses neither write nor clear anything
assign wr_en = access & pwrite & mapped;
assign rd_en = access & ~pwrite & mapped;
assign idx = paddr[7:2];
assign sci_mode = sd_ctl_reg[`SCGC_SD_SCI_BIT];
assign cur_index = eq_ctl_reg[`SCGC_EQ_ADR_HI:`SCGC_EQ_ADR_LO];
////////////////////////////////////////////////////////////////////////////////
// address decode, used by both read mux and error answer
function is_mapped;
	input [5:0] i;
	begin
		is_mapped = (i >= `SCGC_IDX_EQ_CTL) && (i <= `SCGC_IDX_IRQ_MASK)
			&& (paddr[1:0] == 2'h0);
	end
endfunction
assign mapped = is_mapped(idx);
// one strobe decode shared by every host-writable register
function wr_hit;
	input [5:0] i;
	begin
		wr_hit = wr_en && (idx == i);
	end
endfunction
////////////////////////////////////////////////////////////////////////////////
// no wait state: setup, then access answered at once
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end
	else
	begin
		pready <= psel & ~penable;
		pslverr <= psel & ~penable & ~is_mapped(idx);
		if (psel & ~penable & ~pwrite)
			prdata <= mapped ? {16'h0000, rd_word} : 32'h00000000;
	end
end
////////////////////////////////////////////////////////////////////////////////
// change speed write merges only speed
always @*
begin
	if (pwdata[`SCGC_SD_CS_BIT])
		sd_ctl_next = (sd_ctl_reg & ~`SCGC_SPD_MASK) | (pwdata[15:0] & `SCGC_SPD_MASK);
	else
		sd_ctl_next = pwdata[15:0] & `SCGC_SD_CTL_MASK;
end
////////////////////////////////////////////////////////////////////////////////
always @*
begin
	case (idx)
		`SCGC_IDX_EQ_CTL: rd_word = eq_ctl_reg;
		`SCGC_IDX_EQ_COEF: rd_word = (cur_index < EQ_NUM) ? coef_mem[cur_index] : `SCGC_ZERO16;
		`SCGC_IDX_SC_CTL: rd_word = sc_ctl_reg;
		`SCGC_IDX_SC_TIME: rd_word = sc_time_reg;
		`SCGC_IDX_SC_FILT: rd_word = sc_filt_reg;
		`SCGC_IDX_ENC_DATA: rd_word = enc_data_reg;
		`SCGC_IDX_SD_CTL: rd_word = sd_ctl_reg;
		`SCGC_IDX_SD_NOISE: rd_word = sd_noise_reg;
		`SCGC_IDX_DEC_DATA: rd_word = dec_data_reg;
		`SCGC_IDX_STATUS: rd_word = {15'h0000, drq_reg};
		`SCGC_IDX_GC_CTL: rd_word = gc_ctl_reg;
		`SCGC_IDX_GC_ATT: rd_word = gc_att_reg;
		`SCGC_IDX_GC_INIT: rd_word = gc_init_reg;
		`SCGC_IDX_GC_SPEED: rd_word = gc_speed_reg;
		`SCGC_IDX_GC_MAX: rd_word = gc_max_reg;
		`SCGC_IDX_GC_DECAY: rd_word = gc_decay_reg;
		`SCGC_IDX_IRQ_STAT: rd_word = {14'h0000, irq_stat_reg};
		`SCGC_IDX_IRQ_MASK: rd_word = {14'h0000, irq_mask_reg};
		default: rd_word = `SCGC_ZERO16;
	endcase
end
////////////////////////////////////////////////////////////////////////////////
// coefficient store at current index
genvar g;
generate
	for (g = 0; g < EQ_NUM; g = g + 1)
	begin : coef_gen
		always @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				coef_mem[g] <= `SCGC_ZERO16;
			else if (wr_hit(`SCGC_IDX_EQ_COEF) && cur_index == g)
				coef_mem[g] <= pwdata[15:0];
		end
	end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// enable and coefficient index
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		eq_ctl_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_EQ_CTL))
		eq_ctl_reg <= pwdata[15:0];
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		sc_ctl_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_SC_CTL))
		sc_ctl_reg <= pwdata[15:0];
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		sc_time_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_SC_TIME))
		sc_time_reg <= pwdata[15:0];
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		sc_filt_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_SC_FILT))
		sc_filt_reg <= pwdata[15:0] & `SCGC_NOISE_MASK;
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		sd_ctl_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_SD_CTL))
		sd_ctl_reg <= sd_ctl_next;
end
// noise scale, bit 15 reads zero
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		sd_noise_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_SD_NOISE))
		sd_noise_reg <= pwdata[15:0] & `SCGC_NOISE_MASK;
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gc_ctl_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_GC_CTL))
		gc_ctl_reg <= pwdata[15:0];
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gc_att_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_GC_ATT))
		gc_att_reg <= pwdata[15:0] & `SCGC_NOISE_MASK;
end
// compare level and initial gain
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gc_init_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_GC_INIT))
		gc_init_reg <= pwdata[15:0];
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gc_speed_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_GC_SPEED))
		gc_speed_reg <= pwdata[15:0];
end
// maximum gain and attenuation
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gc_max_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_GC_MAX))
		gc_max_reg <= pwdata[15:0];
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gc_decay_reg <= `SCGC_ZERO16;
	else if (wr_hit(`SCGC_IDX_GC_DECAY))
		gc_decay_reg <= pwdata[15:0];
end
// interrupt mask, same layout as status
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		irq_mask_reg <= 2'h0;
	else if (wr_hit(`SCGC_IDX_IRQ_MASK))
		irq_mask_reg <= pwdata[1:0];
end
////////////////////////////////////////////////////////////////////////////////
// encoder word capture only in register transfer mode
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		enc_data_reg <= `SCGC_ZERO16;
	else if (enc_word_valid && sci_mode)
		enc_data_reg <= enc_word;
end
////////////////////////////////////////////////////////////////////////////////
// request flag: hardware set wins over host write clear
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		drq_reg <= 1'b0;
		dec_data_reg <= `SCGC_ZERO16;
		dec_word <= `SCGC_ZERO16;
		dec_word_valid <= 1'b0;
	end
	else
	begin
		dec_word_valid <= 1'b0;
		if (wr_hit(`SCGC_IDX_DEC_DATA))
		begin
			dec_data_reg <= pwdata[15:0];
			dec_word <= pwdata[15:0];
			dec_word_valid <= sci_mode;
		end
		if (dec_word_req && sci_mode)
			drq_reg <= 1'b1;
		else if (wr_hit(`SCGC_IDX_DEC_DATA))
			drq_reg <= 1'b0;
	end
end
////////////////////////////////////////////////////////////////////////////////
// sticky events; read clears, but a new event in that cycle survives
always @*
begin
	irq_set = 2'h0;
	irq_set[`SCGC_IRQ_ENC] = enc_word_valid & sci_mode;
	irq_set[`SCGC_IRQ_DRQ] = dec_word_req & sci_mode;
end
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		irq_stat_reg <= 2'h0;
		irq <= 1'b0;
	end
	else
	begin
		if (rd_en && idx == `SCGC_IDX_IRQ_STAT)
			irq_stat_reg <= irq_set;
		else
			irq_stat_reg <= irq_stat_reg | irq_set;
		irq <= |(irq_stat_reg & irq_mask_reg);
	end
end
////////////////////////////////////////////////////////////////////////////////
// registered copies to the processing core
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		eq_enable <= 1'b0;
		eq_coef_index <= 6'h00;
		eq_coef_value <= `SCGC_ZERO16;
		coder_ctl <= `SCGC_ZERO16;
		coder_time_level <= `SCGC_ZERO16;
		coder_filter_gap <= `SCGC_ZERO16;
		decoder_ctl <= `SCGC_ZERO16;
		decoder_noise <= `SCGC_ZERO16;
		gain_ctl <= `SCGC_ZERO16;
		gain_att <= `SCGC_ZERO16;
		gain_init <= `SCGC_ZERO16;
		gain_speed <= `SCGC_ZERO16;
		gain_max <= `SCGC_ZERO16;
		gain_decay <= `SCGC_ZERO16;
	end
	else
	begin
		eq_enable <= eq_ctl_reg[`SCGC_EQ_EN_BIT];
		eq_coef_index <= cur_index;
		eq_coef_value <= (cur_index < EQ_NUM) ? coef_mem[cur_index] : `SCGC_ZERO16;
		coder_ctl <= sc_ctl_reg;
		coder_time_level <= sc_time_reg;
		coder_filter_gap <= sc_filt_reg;
		decoder_ctl <= sd_ctl_reg;
		decoder_noise <= sd_noise_reg;
		gain_ctl <= gc_ctl_reg;
		gain_att <= gc_att_reg;
		gain_init <= gc_init_reg;
		gain_speed <= gc_speed_reg;
		gain_max <= gc_max_reg;
		gain_decay <= gc_decay_reg;
	end
end
endmodule // scgc_regs
`default_nettype wire

// >>> scgc_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module scgc_regs_properties (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire dec_word_valid,
	input wire [15:0] dec_word,
	input wire eq_enable,
	input wire [5:0] eq_coef_index
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire done = psel && penable && pready;
wire wr_eq = done && pwrite && !pslverr && paddr == 8'hB8;
wire wr_dd = done && pwrite && !pslverr && paddr == 8'hD8;
wire [15:0] wdat = pwdata[15:0];
////////////////////////////////
sequence s_setup;
	psel && !penable;
endsequence
sequence s_read;
	done && !pwrite;
endsequence
property p_answer;
	s_setup |=> done;
endproperty
property p_pulse;
	done |=> !pready;
endproperty
property p_eq_en;
	wr_eq && pwdata[15] |-> ##[1:2] eq_enable;
endproperty
property p_eq_idx;
	$changed(eq_coef_index) |-> $past(wr_eq) || $past(wr_eq, 2);
endproperty
property p_err;
	s_setup and (paddr[1:0] != 2'b00) |=> pslverr;
endproperty
property p_upper;
	s_read |-> prdata[31:16] == 16'h0000;
endproperty
property p_cs;
	s_read ##0 paddr == 8'hD0 |-> !prdata[14];
endproperty
property p_dv;
	dec_word_valid |-> ($past(wr_dd) && dec_word == $past(wdat))
		|| ($past(wr_dd, 2) && dec_word == $past(wdat, 2));
endproperty
a_answer: assert property (p_answer) else $error("no answer after setup");
a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
a_eq_en: assert property (p_eq_en) else $error("equalizer not enabled");
a_eq_idx: assert property (p_eq_idx) else $error("index moved without write");
a_err: assert property (p_err) else $error("misaligned access accepted");
a_upper: assert property (p_upper) else $error("upper read bits set");
a_cs: assert property (p_cs) else $error("change speed reads one");
a_dv: assert property (p_dv) else $error("decoder word not from host write");
endmodule // scgc_regs_properties
bind scgc_regs scgc_regs_properties i_scgc_regs_properties (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .dec_word_valid(dec_word_valid),
	.dec_word(dec_word), .eq_enable(eq_enable), .eq_coef_index(eq_coef_index));
`default_nettype wire

// >>> scgc_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module scgc_regs_tb;
logic pclk, presetn, psel, penable, pwrite, enc_go, dec_go;
logic [7:0] paddr;
logic [31:0] pwdata, rd;
logic [15:0] enc_val;
wire [31:0] prdata;
wire pready, pslverr, ewv, dwr, dec_word_valid, eq_enable, irq;
wire [15:0] enc_word, dec_word, coder_ctl, decoder_ctl;
wire [15:0] eq_coef_value, coder_time_level, coder_filter_gap, decoder_noise;
wire [15:0] gain_ctl, gain_att, gain_init, gain_speed, gain_max, gain_decay;
wire [5:0] eq_coef_index;
int failures = 0;
int n_tests = 0;
scgc_regs i_scgc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .enc_word_valid(ewv), .enc_word(enc_word), .dec_word_req(dwr),
	.dec_word(dec_word), .dec_word_valid(dec_word_valid), .eq_enable(eq_enable),
	.eq_coef_index(eq_coef_index), .eq_coef_value(eq_coef_value), .coder_ctl(coder_ctl),
	.coder_time_level(coder_time_level), .coder_filter_gap(coder_filter_gap),
	.decoder_ctl(decoder_ctl), .decoder_noise(decoder_noise), .gain_ctl(gain_ctl),
	.gain_att(gain_att), .gain_init(gain_init), .gain_speed(gain_speed), .gain_max(gain_max),
	.gain_decay(gain_decay),
	.irq(irq));
scgc_core_model i_scgc_core_model (.pclk(pclk), .presetn(presetn), .enc_go(enc_go),
	.dec_go(dec_go), .enc_val(enc_val), .enc_word_valid(ewv), .enc_word(enc_word),
	.dec_word_req(dwr));
////////////////////////////////
task automatic end_of_test;
	$display("checks %0d failures %0d", n_tests, failures);
	if (failures == 0 && n_tests > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp)
	begin
		failures++;
		$display("FAIL %0t got %h want %h", $time, got, exp);
	end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic e);
	int i;
	@(posedge pclk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= {16'h0000, d};
	@(posedge pclk);
	penable <= 1'b1;
	i = 0;
	do
	begin
		@(posedge pclk);
		i++;
	end
	while (pready !== 1'b1 && i < 20);
	if (i >= 20)
	begin
		failures++;
		end_of_test;
	end
	else
	begin
		rd = prdata;
		chk({31'h0, pslverr}, {31'h0, e});
		psel <= 1'b0;
		penable <= 1'b0;
	end
endtask
task automatic wr(input logic [7:0] a, input logic [15:0] d);
	bus(1'b1, a, d, 1'b0);
endtask
task automatic rdc(input logic [7:0] a, input logic [15:0] x);
	bus(1'b0, a, 16'h0000, 1'b0);
	chk(rd, {16'h0000, x});
endtask
task automatic pulse(input logic enc);
	@(posedge pclk);
	if (enc)
		enc_go <= 1'b1;
	else
		dec_go <= 1'b1;
	@(posedge pclk);
	enc_go <= 1'b0;
	dec_go <= 1'b0;
	repeat (3) @(posedge pclk);
endtask
////////////////////////////////
task automatic t_eq;
	int i;
	for (i = 0; i < 36; i++)
	begin
		wr(8'hB8, 16'h8000 | 16'(i << 8));
		wr(8'hBC, (i == 17 || i == 35) ? 16'h0100 : 16'h8000 + 16'(i));
	end
	for (i = 35; i >= 0; i--)
	begin
		wr(8'hB8, 16'h8000 | 16'(i << 8));
		rdc(8'hBC, (i == 17 || i == 35) ? 16'h0100 : 16'h8000 + 16'(i));
		chk({25'h0, eq_enable, eq_coef_index}, 32'h40 | i);
		chk({16'h0, eq_coef_value}, (i == 17 || i == 35) ? 32'h0100 : 32'h8000 + i);
	end
	wr(8'hB8, 16'h0000);
	repeat (2) @(posedge pclk);
	chk({31'h0, eq_enable}, 32'h0);
endtask
task automatic t_coder;
	logic [15:0] q[4] = '{16'h8000, 16'hC000, 16'hD000, 16'hAC00};
	int i;
	for (i = 0; i < 4; i++)
	begin
		wr(8'hC0, q[i]);
		rdc(8'hC0, q[i]);
		chk({16'h0, coder_ctl}, {16'h0, q[i]});
	end
	wr(8'hC4, 16'h4000);
	rdc(8'hC4, 16'h4000);
	wr(8'hC8, 16'hFFFF);
	rdc(8'hC8, 16'h7FFF);
	chk({coder_time_level, coder_filter_gap}, 32'h40007FFF);
endtask
task automatic t_dec;
	int s;
	wr(8'hD0, 16'hBFFF);
	rdc(8'hD0, 16'h8133);
	for (s = 0; s < 4; s++)
	begin
		wr(8'hD0, 16'h4000 | 16'(s));
		rdc(8'hD0, 16'h8130 | 16'(s));
		chk({16'h0, decoder_ctl}, 32'h8130 | s);
	end
	wr(8'hD4, 16'hFFFF);
	rdc(8'hD4, 16'h7FFF);
	chk({16'h0, decoder_noise}, 32'h7FFF);
endtask
task automatic t_xfer;
	wr(8'hD0, 16'h8100);
	wr(8'hFC, 16'h0003);
	enc_val <= 16'hA5C3;
	pulse(1'b1);
	chk({31'h0, irq}, 32'h1);
	rdc(8'hCC, 16'hA5C3);
	rdc(8'hF8, 16'h0001);
	pulse(1'b0);
	rdc(8'hDC, 16'h0001);
	rdc(8'hF8, 16'h0002);
	wr(8'hD8, 16'h1234);
	@(posedge pclk);
	chk({31'h0, dec_word_valid}, 32'h1);
	rdc(8'hDC, 16'h0000);
	chk({16'h0, dec_word}, 32'h1234);
	wr(8'hFC, 16'h0000);
	pulse(1'b1);
	chk({31'h0, irq}, 32'h0);
	wr(8'hD0, 16'h8000);
	enc_val <= 16'h5A3C;
	pulse(1'b1);
	pulse(1'b0);
	rdc(8'hCC, 16'hA5C3);
	rdc(8'hDC, 16'h0000);
	wr(8'hD8, 16'h4321);
	@(posedge pclk);
	chk({31'h0, dec_word_valid}, 32'h0);
endtask
task automatic t_gain;
	logic [7:0] a[5] = '{8'hE0, 8'hE8, 8'hEC, 8'hF0, 8'hF4};
	int i;
	for (i = 0; i < 5; i++)
	begin
		wr(a[i], 16'hA55A ^ 16'(i));
		rdc(a[i], 16'hA55A ^ 16'(i));
	end
	chk({gain_ctl, gain_init}, 32'hA55AA55B);
	chk({gain_speed, gain_max}, 32'hA558A559);
	chk({16'h0, gain_decay}, 32'hA55E);
	wr(8'hE4, 16'hFFFF);
	rdc(8'hE4, 16'h7FFF);
	chk({16'h0, gain_att}, 32'h7FFF);
	bus(1'b1, 8'hBA, 16'hFFFF, 1'b1);
	rdc(8'hB8, 16'h0000);
	bus(1'b1, 8'h00, 16'hFFFF, 1'b1);
	bus(1'b0, 8'hBD, 16'h0000, 1'b1);
	chk(rd, 32'h0);
endtask
////////////////////////////////
initial
begin
	pclk = 1'b0;
	forever #4 pclk = ~pclk;
end
initial
begin
	{presetn, psel, penable, pwrite, enc_go, dec_go} = 6'h00;
	paddr = 8'h00;
	pwdata = 32'h0;
	enc_val = 16'h0000;
	repeat (6) @(posedge pclk);
	presetn <= 1'b1;
	rdc(8'hB8, 16'h0000);
	rdc(8'hC0, 16'h0000);
	rdc(8'hD0, 16'h0000);
	t_eq;
	t_coder;
	t_dec;
	t_xfer;
	t_gain;
	end_of_test;
end
endmodule // scgc_regs_tb
`default_nettype wire
